/* File: design/fpec_map.svh */
// Purpose: offsets, field positions and reset values of the flash program/erase control block
// Assumes: word-addressed register port, 16-bit data path
// Notes: definitions only
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
`define FPEC_CTL_OFS 8'h08
`define FPEC_SHD0_OFS 8'h00
`define FPEC_STAT_OFS 8'h0A
`define FPEC_ARR_BASE 8'h80
`define FPEC_HV_BIT 0
`define FPEC_LAT_BIT 1
`define FPEC_ERS_BIT 2
`define FPEC_VFY_BIT 3
`define FPEC_CTL_RST 16'h0000
`define FPEC_ERASED_WORD 16'hFFFF
`define FPEC_SHD_WORDS 4
`endif

/* File: design/fpec_pkg.sv */
// Purpose: shared types of the flash program/erase control block
// Assumes: nothing beyond the map header
// Notes: types only
`default_nettype none
package fpec_pkg;
    typedef enum logic [3:0] {
        FPEC_IDLE = 4'b0001,
        FPEC_ARMED = 4'b0010,
        FPEC_HV = 4'b0100,
        FPEC_RECOV = 4'b1000
    } fpec_state_t;
    typedef enum logic [1:0] {
        FPEC_OP_NONE = 2'h0,
        FPEC_OP_PROG = 2'h1,
        FPEC_OP_ERASE = 2'h2
    } fpec_op_t;
endpackage
`default_nettype wire

/* File: design/fpec_cell_if.sv */
// Purpose: carrier between control logic and the cell array
// Assumes: one clock domain
// Notes: one pulse per program or erase cycle of the high voltage
`default_nettype none
interface fpec_cell_if #(parameter int AW = 7, parameter int DW = 16);
    logic [AW-1:0] addr;
    logic [DW-1:0] pdata;
    logic [1:0] bmask;
    logic prog_en;
    logic erase_en;
    logic [DW-1:0] rdata;
    modport ctl (output addr, output pdata, output bmask, output prog_en, output erase_en, input rdata);
    modport mem (input addr, input pdata, input bmask, input prog_en, input erase_en, output rdata);
endinterface
`default_nettype wire

/* File: design/fpec_cell_array.sv */
// Purpose: nonvolatile cell model, registered read data
// Assumes: prog_en and erase_en never both high
// Notes: programming only clears bits, erase sets every word to ones
`include "fpec_map.svh"
`default_nettype none
module fpec_cell_array #(
    parameter int AW = 7,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    fpec_cell_if.mem cif
);
    logic [DW-1:0] mem_r [2**AW];
    logic [DW-1:0] rd_r;
    logic [DW-1:0] keep;

    always_comb begin
        keep = '1;
        if (cif.bmask[0]) begin
            keep[DW/2-1:0] = cif.pdata[DW/2-1:0];
        end
        if (cif.bmask[1]) begin
            keep[DW-1:DW/2] = cif.pdata[DW-1:DW/2];
        end
    end

    // no reset on the cells: they model storage that survives reset
    always_ff @(posedge clk) begin
        if (cif.erase_en) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_r[i] <= `FPEC_ERASED_WORD;
            end
        end else if (cif.prog_en) begin
            mem_r[cif.addr] <= mem_r[cif.addr] & keep;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_r <= '0;
        end else begin
            rd_r <= mem_r[cif.addr];
        end
    end

    assign cif.rdata = rd_r;
endmodule // fpec_cell_array

/* File: design/fpec_ctrl.sv */
// Purpose: program/erase control of one flash module: control register, latches, verify, read mux
// Assumes: register port, reads answer one cycle later; software times every pulse
// Notes: array words sit at FPEC_ARR_BASE upward, shadow words at the low offsets
`include "fpec_map.svh"
`default_nettype none
module fpec_ctrl
    import fpec_pkg::*;
#(
    parameter int AW = 7,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    output logic reg_err,
    output logic program_voltage_req,
    output logic busy
);
    fpec_cell_if #(.AW(AW), .DW(DW)) cif ();

    logic erase_select_r;
    logic latch_enable_r;
    logic high_voltage_enable_r;
    logic verify_select_r;
    logic latched_r;
    fpec_op_t op_r;
    fpec_state_t state_r;
    fpec_state_t state_nxt;
    logic [AW-1:0] lat_addr_r;
    logic [DW-1:0] lat_data_r;
    logic [1:0] lat_mask_r;
    logic [7:0] lat_reg_r;
    logic [1:0] rd_kind_r;
    logic reg_err_r;
    logic pv_r;
    logic busy_r;

    localparam logic [1:0] RK_ARR = 2'h0;
    localparam logic [1:0] RK_CTL = 2'h1;
    localparam logic [1:0] RK_NONE = 2'h2;
    localparam logic [1:0] RK_STAT = 2'h3;

    // shadow words share array index space at the top of the cell store
    function automatic logic [AW-1:0] fpec_index(input logic [7:0] a);
        if (a >= `FPEC_ARR_BASE) begin
            fpec_index = AW'(a - `FPEC_ARR_BASE);
        end else begin
            fpec_index = AW'(2**AW - `FPEC_SHD_WORDS) + AW'(a[1:0]);
        end
    endfunction

    function automatic logic fpec_valid(input logic [7:0] a);
        fpec_valid = (a >= `FPEC_ARR_BASE) || (a < 8'(`FPEC_SHD_WORDS));
    endfunction

    wire ctl_hit = reg_addr == `FPEC_CTL_OFS;
    wire valid_hit = fpec_valid(reg_addr);
    // only one byte or a whole aligned word counts as a legal program write
    wire mask_ok = reg_be != 2'b00;

    // control bits; the high-voltage bit freezes the other three
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            erase_select_r <= 1'b0;
            latch_enable_r <= 1'b0;
            verify_select_r <= 1'b0;
            high_voltage_enable_r <= 1'b0;
        end else if (reg_wr && ctl_hit) begin
            if (!high_voltage_enable_r) begin
                erase_select_r <= reg_wdata[`FPEC_ERS_BIT];
                latch_enable_r <= reg_wdata[`FPEC_LAT_BIT];
                verify_select_r <= reg_wdata[`FPEC_VFY_BIT];
            end
            high_voltage_enable_r <= reg_wdata[`FPEC_HV_BIT] && latch_enable_r && latched_r;
        end
    end

    // programming latches: first valid write after latch enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latched_r <= 1'b0;
            lat_addr_r <= '0;
            lat_data_r <= '0;
            lat_mask_r <= 2'b00;
            lat_reg_r <= 8'h00;
            op_r <= FPEC_OP_NONE;
        end else if (!latch_enable_r) begin
            latched_r <= 1'b0;
            op_r <= FPEC_OP_NONE;
        end else if (reg_wr && valid_hit && !latched_r && !high_voltage_enable_r && mask_ok) begin
            latched_r <= 1'b1;
            lat_addr_r <= fpec_index(reg_addr);
            lat_reg_r <= reg_addr;
            lat_data_r <= reg_wdata;
            lat_mask_r <= erase_select_r ? 2'b11 : reg_be;
            op_r <= erase_select_r ? FPEC_OP_ERASE : FPEC_OP_PROG;
        end
    end

    // sequence view for status only; pulse length comes from software alone
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FPEC_IDLE: begin
                if (latched_r) begin
                    state_nxt = FPEC_ARMED;
                end
            end
            FPEC_ARMED: begin
                if (high_voltage_enable_r) begin
                    state_nxt = FPEC_HV;
                end else if (!latched_r) begin
                    state_nxt = FPEC_IDLE;
                end
            end
            FPEC_HV: begin
                if (!high_voltage_enable_r) begin
                    state_nxt = FPEC_RECOV;
                end
            end
            FPEC_RECOV: begin
                state_nxt = latched_r ? FPEC_ARMED : FPEC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= FPEC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // array drive follows the bit cycle by cycle, no timer
    assign cif.prog_en = high_voltage_enable_r && op_r == FPEC_OP_PROG;
    assign cif.erase_en = high_voltage_enable_r && op_r == FPEC_OP_ERASE;
    assign cif.pdata = lat_data_r;
    assign cif.bmask = lat_mask_r;
    // latches steer the array address while enabled, else the bus does
    assign cif.addr = latch_enable_r ? lat_addr_r : fpec_index(reg_addr);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pv_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            pv_r <= reg_wr && ctl_hit ? reg_wdata[`FPEC_HV_BIT] && latch_enable_r && latched_r
                                      : high_voltage_enable_r;
            busy_r <= latch_enable_r || (reg_wr && ctl_hit && reg_wdata[`FPEC_LAT_BIT]);
        end
    end

    // read kind is decided at the strobe, the cell data arrive a cycle later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_kind_r <= RK_NONE;
            reg_err_r <= 1'b0;
        end else begin
            reg_err_r <= 1'b0;
            rd_kind_r <= RK_NONE;
            if (reg_rd) begin
                if (ctl_hit) begin
                    rd_kind_r <= RK_CTL;
                end else if (reg_addr == `FPEC_STAT_OFS) begin
                    rd_kind_r <= RK_STAT;
                end else if (valid_hit && !high_voltage_enable_r) begin
                    rd_kind_r <= RK_ARR;
                end else begin
                    reg_err_r <= !valid_hit;
                end
            end
        end
    end

    logic [DW-1:0] rd_val;
    always_comb begin
        rd_val = '0;
        unique case (rd_kind_r)
            RK_CTL: begin
                rd_val[`FPEC_VFY_BIT] = verify_select_r;
                rd_val[`FPEC_ERS_BIT] = erase_select_r;
                rd_val[`FPEC_LAT_BIT] = latch_enable_r;
                rd_val[`FPEC_HV_BIT] = high_voltage_enable_r;
            end
            RK_STAT: begin
                rd_val = DW'({op_r, state_r, latched_r});
            end
            RK_ARR: begin
                if (!latch_enable_r) begin
                    rd_val = cif.rdata;
                end else if (verify_select_r && !erase_select_r) begin
                    rd_val = cif.rdata ^ lat_data_r;
                end else if (erase_select_r) begin
                    rd_val = cif.rdata;
                end else begin
                    rd_val = DW'(lat_reg_r);
                end
            end
            RK_NONE: begin
                rd_val = '0;
            end
        endcase
    end

    fpec_cell_array #(.AW(AW), .DW(DW)) u_cells (
        .clk(clk),
        .arst_n(arst_n),
        .cif(cif)
    );

    // read data mux sits behind the registered cell data and read kind, so the
    // answer stands in the cycle right after the strobe and is zero otherwise
    assign reg_rdata = rd_val;
    assign reg_err = reg_err_r;
    assign program_voltage_req = pv_r;
    assign busy = busy_r;
endmodule // fpec_ctrl
`default_nettype wire

/* File: testbench/fpec_ctrl_props.sv */
// Purpose: port checks on the flash program/erase control
// Assumes: one clock, async active-low reset
// Notes: bound to fpec_ctrl below
`include "fpec_map.svh"
`default_nettype none
module fpec_ctrl_props #(
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic reg_err,
    input wire logic program_voltage_req,
    input wire logic busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic ctl_wr;
    logic hv_set_wr;
    logic rd_bad;
    // quiet write: hv bit known clear, so control bits may change
    logic quiet;
    assign ctl_wr = reg_wr && (reg_addr == `FPEC_CTL_OFS);
    assign hv_set_wr = ctl_wr && reg_wdata[`FPEC_HV_BIT];
    assign rd_bad = reg_rd && !reg_addr[7] && (reg_addr > 8'h03) && (reg_addr != `FPEC_CTL_OFS)
        && (reg_addr != `FPEC_STAT_OFS);
    assign quiet = !program_voltage_req;
    sequence s_hv_held;
        program_voltage_req ##1 program_voltage_req;
    endsequence
    sequence s_ctl_set(logic [3:0] v);
        ctl_wr && (reg_wdata[3:0] == v) && quiet && !$past(reg_wr);
    endsequence
    property p_hv_rise;
        $rose(program_voltage_req) |-> $past(hv_set_wr);
    endproperty
    property p_hv_drop;
        ctl_wr && !reg_wdata[`FPEC_HV_BIT] |-> ##1 !program_voltage_req;
    endproperty
    property p_hv_latch;
        $rose(program_voltage_req) |-> busy;
    endproperty
    property p_hv_freeze;
        s_hv_held |-> $stable(busy);
    endproperty
    property p_hv_read;
        reg_rd && reg_addr[7] && program_voltage_req && !$past(reg_wr) |=> reg_rdata == '0;
    endproperty
    property p_latch_on;
        s_ctl_set(4'h2) |-> ##[1:2] busy;
    endproperty
    property p_latch_off;
        s_ctl_set(4'h0) |-> ##2 !busy;
    endproperty
    property p_err;
        rd_bad |=> reg_err && (reg_rdata == '0);
    endproperty
    property p_err_cause;
        reg_err |-> $past(rd_bad);
    endproperty
    a_hv_rise: assert property (p_hv_rise) else $error("hv request rose without a set write");
    a_hv_drop: assert property (p_hv_drop) else $error("hv request outlived its clear");
    a_hv_latch: assert property (p_hv_latch) else $error("hv request without latch enable");
    a_hv_freeze: assert property (p_hv_freeze) else $error("latch changed under hv");
    a_hv_read: assert property (p_hv_read) else $error("array read answered under hv");
    a_latch_on: assert property (p_latch_on) else $error("latch enable not taken");
    a_latch_off: assert property (p_latch_off) else $error("latch enable not cleared");
    a_err: assert property (p_err) else $error("unmapped read not flagged");
    a_err_cause: assert property (p_err_cause) else $error("error flag without cause");
endmodule // fpec_ctrl_props
bind fpec_ctrl fpec_ctrl_props #(.DW(DW)) u_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_err(reg_err), .program_voltage_req(program_voltage_req), .busy(busy));
`default_nettype wire

/* File: testbench/fpec_ctrl_tb_top.sv */
// Purpose: directed bench for the flash program/erase control
// Assumes: cells start unknown, so the array is erased first
// Notes: pulse lengths are short; the block has no pulse timer
`include "fpec_map.svh"
`default_nettype none
module fpec_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0] reg_be = 2'h3;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic reg_err;
    logic program_voltage_req;
    logic busy;
    logic [15:0] rd_val;
    logic [7:0] blank_addr [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'h85, 8'hFF};
    int failures = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    fpec_ctrl #(.AW(7), .DW(16)) uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_err(reg_err),
        .program_voltage_req(program_voltage_req), .busy(busy));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        rd(a);
        check_word(rd_val, exp);
    endtask
    task automatic ctl(input logic [15:0] d);
        wr(`FPEC_CTL_OFS, d, 2'h3);
    endtask
    // hv request lags the control write by one cycle
    task automatic hv_chk(input logic exp);
        @(posedge clk);
        #1;
        check_flag(program_voltage_req, exp);
    endtask
    task automatic prog(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        ctl(16'h0002);
        wr(a, d, be);
        ctl(16'h0003);
        repeat (4) @(posedge clk);
        ctl(16'h0002);
        repeat (2) @(posedge clk);
        ctl(16'h0003);
        repeat (4) @(posedge clk);
        ctl(16'h0002);
        ctl(16'h0000);
    endtask
    initial begin
        #100us;
        failures++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check_flag(busy, 1'b0);
        check_flag(program_voltage_req, 1'b0);
        ctl(16'h0006);
        wr(8'h90, 16'h5A5A, 2'h3);
        ctl(16'h0007);
        hv_chk(1'b1);
        ctl(16'h0006);
        hv_chk(1'b0);
        rd_chk(8'h85, 16'hFFFF);
        ctl(16'h0007);
        hv_chk(1'b1);
        ctl(16'h0006);
        ctl(16'h0000);
        foreach (blank_addr[i]) rd_chk(blank_addr[i], `FPEC_ERASED_WORD);
        ctl(16'h0001);
        hv_chk(1'b0);
        ctl(16'h0002);
        wr(8'h85, 16'h0000, 2'h0);
        ctl(16'h0003);
        hv_chk(1'b0);
        ctl(16'h0002);
        wr(8'h85, 16'h1234, 2'h3);
        rd_chk(`FPEC_STAT_OFS, 16'h0025);
        rd_chk(8'h85, 16'h0085);
        ctl(16'h0003);
        hv_chk(1'b1);
        rd_chk(8'h85, 16'h0000);
        ctl(16'h000B);
        ctl(16'h0002);
        hv_chk(1'b0);
        rd_chk(8'h85, 16'h0085);
        ctl(16'h000A);
        rd_chk(8'h85, 16'h0000);
        ctl(16'h0000);
        rd_chk(8'h85, 16'h1234);
        prog(8'h85, 16'hFF00, 2'h3);
        rd_chk(8'h85, 16'h1200);
        prog(8'h86, 16'h00F0, 2'h1);
        rd_chk(8'h86, 16'hFFF0);
        prog(8'h87, 16'h00F0, 2'h2);
        rd_chk(8'h87, 16'h00FF);
        prog(8'h01, 16'h0F0F, 2'h3);
        rd_chk(8'h01, 16'h0F0F);
        rd(8'h40);
        check_flag(reg_err, 1'b1);
        check_word(rd_val, 16'h0000);
        wrap_up;
    end
endmodule // fpec_ctrl_tb_top
`default_nettype wire
